/* File: verilog/aims_pkg.sv */
// Constants for the converter input multiplexer select registers
// Summary of operation
// - Positive codes 0-15 pick port 0 pins 0-7 then port 1 pins 0-7.
// - Positive code 16 picks temperature sensor, 17 picks supply rail.
// - Negative codes 0-15 pick port pins likewise; 16 picks voltage reference.
// - Negative code 17 picks ground and makes conversions single-ended.
// - Any other negative selection means differential conversion.
// - Codes 18-21 pick port 2 pins 0-3 on large packages; 22-31 none.
// - Sensor enable powers the sensor; disabled output floats, results invalid.
package aims_pkg;
  localparam logic [7:0] NEG_SEL_ADDR = 8'hba;
  localparam logic [7:0] POS_SEL_ADDR = 8'hbb;
  localparam logic [4:0] SEL_RESET = 5'h1f;
  localparam int SEL_W = 5;
  localparam int SRC_W = 22;
  localparam logic [4:0] CODE_PORT_LAST = 5'h0f;
  localparam logic [4:0] CODE_TEMP = 5'h10;
  localparam logic [4:0] CODE_VREF = 5'h10;
  localparam logic [4:0] CODE_SUPPLY = 5'h11;
  localparam logic [4:0] CODE_GND = 5'h11;
  localparam logic [4:0] CODE_P2_FIRST = 5'h12;
  localparam logic [4:0] CODE_P2_LAST = 5'h15;
endpackage

/* File: verilog/aims_mux_select.sv */
// Select registers and one-hot decode for the converter input multiplexer
`timescale 1ns/1ps
`default_nettype none
module aims_mux_select
  import aims_pkg::*;
#(
  parameter bit LARGE_PACKAGE = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Special-function-register bus
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  // Sensor control from the reference-control register
  input wire logic temp_sensor_enable,
  // Multiplexer selections, one-hot or all zero when no source matches: [15:0] port 0/1, 16, 17, [21:18] port 2
  output logic [SRC_W-1:0] pos_sel,
  output logic [SRC_W-1:0] neg_sel,
  output logic single_ended,
  output logic differential,
  output logic temp_sensor_power,
  output logic temp_result_valid
);
  logic [SEL_W-1:0] positive_input_select;
  logic [SEL_W-1:0] negative_input_select;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      positive_input_select <= SEL_RESET;
    end else if (sfr_wr && sfr_addr == POS_SEL_ADDR) begin
      positive_input_select <= sfr_wdata[SEL_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      negative_input_select <= SEL_RESET;
    end else if (sfr_wr && sfr_addr == NEG_SEL_ADDR) begin
      negative_input_select <= sfr_wdata[SEL_W-1:0];
    end
  end

  always_comb begin
    sfr_hit = sfr_rd && (sfr_addr == POS_SEL_ADDR ||
                         sfr_addr == NEG_SEL_ADDR);
    if (sfr_addr == POS_SEL_ADDR) begin
      sfr_rdata = {3'h0, positive_input_select};
    end else if (sfr_addr == NEG_SEL_ADDR) begin
      sfr_rdata = {3'h0, negative_input_select};
    end else begin
      sfr_rdata = 8'h00;
    end
  end

  // Per-source match; codes above the port 2 range match no source
  logic [SRC_W-1:0] src_present;
  logic [SRC_W-1:0] next_pos_sel;
  logic [SRC_W-1:0] next_neg_sel;

  for (genvar i = 0; i < SRC_W; i++) begin : g_src
    assign src_present[i] = LARGE_PACKAGE || i < CODE_P2_FIRST;
    assign next_pos_sel[i] = src_present[i] &&
      positive_input_select == SEL_W'(i);
    assign next_neg_sel[i] = src_present[i] &&
      negative_input_select == SEL_W'(i);
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pos_sel <= '0;
    end else begin
      pos_sel <= next_pos_sel;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      neg_sel <= '0;
    end else begin
      neg_sel <= next_neg_sel;
    end
  end

  // Ground as negative input is the only single-ended case
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      single_ended <= 1'b0;
    end else begin
      single_ended <= negative_input_select == CODE_GND;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      differential <= 1'b1;
    end else begin
      differential <= negative_input_select != CODE_GND;
    end
  end

  // Sensor reading only meaningful when powered and routed single-ended
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      temp_sensor_power <= 1'b0;
    end else begin
      temp_sensor_power <= temp_sensor_enable;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      temp_result_valid <= 1'b0;
    end else begin
      temp_result_valid <= temp_sensor_enable &&
        positive_input_select == CODE_TEMP &&
        negative_input_select == CODE_GND;
    end
  end

  // Decode checks

  pos_decode_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    sfr_wr && sfr_addr == POS_SEL_ADDR &&
    sfr_wdata[SEL_W-1:0] == CODE_TEMP
    |=> ##1 pos_sel[CODE_TEMP] && $onehot(pos_sel))
    else $error("sensor not selected");

  neg_gnd_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    sfr_wr && sfr_addr == NEG_SEL_ADDR &&
    sfr_wdata[SEL_W-1:0] == CODE_GND
    |=> ##1 single_ended && !differential && neg_sel[CODE_GND])
    else $error("ground not single-ended");

  mode_excl_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    $past(rst_b) |-> single_ended != differential)
    else $error("mode flags clash");

  read_top_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    sfr_rdata[7:5] == 3'h0)
    else $error("upper bits nonzero");

  port_code_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    positive_input_select <= CODE_PORT_LAST
    |=> pos_sel == (22'h1 << $past(positive_input_select)))
    else $error("port decode wrong");

  none_code_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    negative_input_select > CODE_P2_LAST |=> neg_sel == '0)
    else $error("reserved code selects");

  vref_code_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    negative_input_select == CODE_VREF
    |=> neg_sel[CODE_VREF] && $onehot(neg_sel) && differential)
    else $error("reference not selected");

  temp_valid_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    !temp_sensor_enable |=> !temp_result_valid)
    else $error("unpowered sensor valid");

  supply_code_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    positive_input_select == CODE_SUPPLY
    |=> pos_sel[CODE_SUPPLY] && $onehot(pos_sel))
    else $error("supply not selected");

  neg_port_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    negative_input_select <= CODE_PORT_LAST
    |=> neg_sel == (22'h1 << $past(negative_input_select)))
    else $error("negative port decode wrong");

  p2_code_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    positive_input_select >= CODE_P2_FIRST &&
    positive_input_select <= CODE_P2_LAST
    |=> $onehot(pos_sel) == LARGE_PACKAGE)
    else $error("port 2 decode wrong");

  pos_none_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    positive_input_select > CODE_P2_LAST |=> pos_sel == '0)
    else $error("reserved positive code selects");

  diff_mode_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    negative_input_select != CODE_GND |=> differential && !single_ended)
    else $error("differential mode missing");

  // Register write checks

  neg_write_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    sfr_wr && sfr_addr == NEG_SEL_ADDR
    |=> negative_input_select == $past(sfr_wdata[SEL_W-1:0]))
    else $error("negative write lost");

  pos_write_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    sfr_wr && sfr_addr == POS_SEL_ADDR
    |=> positive_input_select == $past(sfr_wdata[SEL_W-1:0]))
    else $error("positive write lost");

  other_addr_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    sfr_wr && sfr_addr != POS_SEL_ADDR && sfr_addr != NEG_SEL_ADDR
    |=> $stable(positive_input_select) && $stable(negative_input_select))
    else $error("foreign write landed");

  // Sensor and reset checks

  power_follow_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    $past(rst_b) |-> temp_sensor_power == $past(temp_sensor_enable))
    else $error("sensor power lags enable");

  temp_valid_set_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    temp_sensor_enable && positive_input_select == CODE_TEMP &&
    negative_input_select == CODE_GND |=> temp_result_valid)
    else $error("sensor reading not valid");

  reset_out_a: assert property (
    @(posedge clk)
    !rst_b |=> pos_sel == '0 && neg_sel == '0 && !single_ended &&
    differential && !temp_sensor_power && !temp_result_valid)
    else $error("outputs not cleared by reset");

endmodule // aims_mux_select
`default_nettype wire

/* File: test/tb.sv */
// Testbench for the converter input multiplexer select registers
`timescale 1ns/1ps
`default_nettype none
module tb
  import aims_pkg::*;
;
  logic clk, rst_b, sfr_wr, sfr_rd, tse, sfr_hit, se, df, tpow, tval;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, rb;
  logic [SRC_W-1:0] pos_sel, neg_sel, pos_sel_s, neg_sel_s;
  int num_errors = 0, checks_done = 0, seed = 90, cyc = 0, p, n;
  // Model of the two fields: entry 0 negative, entry 1 positive
  int model[$];
  aims_mux_select u_aims_mux_select (.clk(clk), .rst_b(rst_b),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
    .temp_sensor_enable(tse), .pos_sel(pos_sel), .neg_sel(neg_sel),
    .single_ended(se), .differential(df), .temp_sensor_power(tpow),
    .temp_result_valid(tval));
  // Small package variant: port 2 codes select nothing
  aims_mux_select #(.LARGE_PACKAGE(1'b0)) u_aims_mux_select_small (
    .clk(clk), .rst_b(rst_b),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_rdata(), .sfr_hit(),
    .temp_sensor_enable(tse), .pos_sel(pos_sel_s), .neg_sel(neg_sel_s),
    .single_ended(), .differential(), .temp_sensor_power(),
    .temp_result_valid());
  function automatic logic [SRC_W-1:0] sel(input int c, input bit big);
    if (c <= 17 || (big && c <= 21)) begin
      return 22'h1 << c;
    end
    return 22'h0;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Strobe stays high across back-to-back writes; caller drops it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    if (a == NEG_SEL_ADDR || a == POS_SEL_ADDR) begin
      model[a - NEG_SEL_ADDR] = int'(d[4:0]);
    end
    @(negedge clk);
  endtask
  // Read strobe stays high across back-to-back reads; caller drops it
  task automatic rdc(input logic [7:0] a);
    sfr_rd = 1'b1;
    sfr_addr = a;
    #1;
    if (a == NEG_SEL_ADDR || a == POS_SEL_ADDR) begin
      chk(sfr_rdata, model[a - NEG_SEL_ADDR]);
      chk(sfr_hit, 1);
    end else begin
      chk(sfr_rdata, 0);
      chk(sfr_hit, 0);
    end
    @(negedge clk);
  endtask
  task automatic do_reset();
    rst_b = 1'b0;
    model = '{int'(SEL_RESET), int'(SEL_RESET)};
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
  endtask
  task automatic test_done();
    $display("Checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc > 2000) begin
      num_errors++;
      test_done();
    end
  end
  initial begin
    {sfr_wr, sfr_rd, tse, sfr_addr, sfr_wdata} = '0;
    do_reset();
    rdc(POS_SEL_ADDR);
    rdc(NEG_SEL_ADDR);
    rdc(8'hbc);
    sfr_rd = 1'b0;
    for (int i = 0; i < 96; i++) begin
      p = $random(seed) & 31;
      n = $random(seed) & 31;
      if (i < 32) begin
        p = i;
      end else if (i < 64) begin
        n = i - 32;
      end else begin
        p = 16;
        n = i[0] ? 17 : n;
      end
      tse = 1'($random(seed));
      rb = 8'($random(seed));
      wr(POS_SEL_ADDR, {rb[7:5], p[4:0]});
      wr(NEG_SEL_ADDR, {rb[2:0], n[4:0]});
      wr(rb[0] ? 8'hb9 : 8'hbc, rb);
      sfr_wr = 1'b0;
      @(negedge clk);
      rdc(POS_SEL_ADDR);
      rdc(NEG_SEL_ADDR);
      sfr_rd = 1'b0;
      chk(pos_sel, sel(p, 1'b1));
      chk(neg_sel, sel(n, 1'b1));
      chk(pos_sel_s, sel(p, 1'b0));
      chk(neg_sel_s, sel(n, 1'b0));
      chk(se, n == 17);
      chk(df, n != 17);
      chk(tpow, tse);
      chk(tval, tse && p == 16 && n == 17);
    end
    // Second reset mid-run, sensor enabled, returns the reset state
    tse = 1'b1;
    do_reset();
    chk(pos_sel, 0);
    chk(neg_sel, 0);
    chk(se, 0);
    chk(df, 1);
    chk(tpow, 0);
    chk(tval, 0);
    rdc(POS_SEL_ADDR);
    rdc(NEG_SEL_ADDR);
    sfr_rd = 1'b0;
    @(negedge clk);
    chk(tpow, tse);
    test_done();
  end
endmodule // tb
`default_nettype wire
